// *** include/lite_timer_pkg.sv ***
// Constants, register map and carrier types of the lite timebase timer
package lite_timer_pkg;
  // Clocking of the block
  localparam int CLK_MHZ = 200;
  localparam int OSC_MHZ = 8;
  localparam int PRESCALE = 32;
  localparam int TICK_CYCLES_DEF = CLK_MHZ * PRESCALE / OSC_MHZ;
  // Timebase 1 periods in oscillator periods
  localparam int TB_SHORT_OSC = 8000;
  localparam int TB_LONG_OSC = 16000;
  // Watchdog interval, microseconds at the nominal oscillator
  localparam int WDG_TIME_US = 2000;
  localparam int WDG_TICKS_DEF = WDG_TIME_US * OSC_MHZ / PRESCALE;
  localparam int HALT_WAKE_CLKS = 4096;
  localparam int TICK_W = 16;
  localparam int WDG_W = 16;
  localparam int HOLD_W = 13;
  // Counter limits
  localparam logic [7:0] CNT1_WRAP = 8'hf9;
  localparam logic [7:0] CNT2_TOP = 8'hff;
  localparam logic [7:0] ZERO8 = 8'h00;
  // Register offsets
  localparam logic [7:0] OFF_CSR2 = 8'h0c;
  localparam logic [7:0] OFF_RELOAD = 8'h0d;
  localparam logic [7:0] OFF_CNT2 = 8'h0e;
  localparam logic [7:0] OFF_CSR1 = 8'h0f;
  localparam logic [7:0] OFF_CAPTURE = 8'h10;
  localparam logic [7:0] OFF_GUARD = 8'h11;
  // Field positions of the second control/status register
  localparam int B_T2IE = 1;
  localparam int B_T2F = 0;
  // Field positions of the first control/status register
  localparam int B_CAPTURE_IRQ_ENABLE = 7;
  localparam int B_ICF = 6;
  localparam int B_TB = 5;
  localparam int B_T1IE = 4;
  localparam int B_T1F = 3;
  // Field positions of the watchdog register
  localparam int B_GEN = 0;
  localparam int B_GREF = 1;
  localparam int B_GCAUSE = 2;
  // Reset values
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic CAPF_RST = 1'b1;
  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_type;
  // Watchdog states
  typedef enum logic [1:0] {
    GUARD_OFF = 2'b00,
    GUARD_HOLD = 2'b01,
    GUARD_RUN = 2'b10
  } guard_state_type;
endpackage : lite_timer_pkg

// *** rtl/lite_timebase_capture_watchdog.sv ***
// Lite timebase, auto-reload counter, input capture and watchdog
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Hidden counter starts at zero, steps every 32 oscillator periods, not visible
// - Hidden counter overflow event on wrap from F9h to 00h
// - Tick is 8000 oscillator periods, or 16000 with period select set
// - Tick sets first flag; interrupt raised when its enable is set
// - Reading first control/status clears first flag; writes leave it alone
// - Pin edge copies hidden counter into capture register, sets capture flag
// - Capture interrupt raised on capture when capture enable is set
// - Reading capture register clears capture flag; writes leave it alone
// - While capture flag set, edges ignored and captured value kept
// - Second counter starts at reload value, steps every 32 oscillator periods
// - Second counter past FFh reloads from reload register, not zero
// - Reload writes take effect only at next second-counter overflow
// - Second overflow sets second flag; interrupt raised when enabled
// - Reading second control/status clears second flag; writes ignored
// - Enabled watchdog resets at the end of any 2 ms interval with no refresh in it
// - Software sets refresh bit; hardware clears it every interval
// - Force bit resets at once; afterwards same bit shows watchdog cause
// - Watchdog cause flag clears itself once read
// - Hardware watchdog option keeps watchdog on, enable bit ignored
// - Halt stops counting; external wake resumes watchdog after 4096 clocks
// - Fixed oscillator divide, so slow, wait, active halt change nothing
module lite_timebase_capture_watchdog
  import lite_timer_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int WDG_TICKS = WDG_TICKS_DEF
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic power_on_reset,
  input wire bus_req_type bus_req,
  output logic [7:0] rd_data,
  input wire logic capture_input_pin,
  input wire logic hw_guard_option,
  input wire logic halt_mode,
  input wire logic wake_ext,
  output logic tick1_irq,
  output logic tick2_irq,
  output logic capture_irq,
  output logic guard_reset
);

  // Read strobe aimed at one register
  function automatic logic rd_hit(input bus_req_type req, input logic [7:0] off);
    rd_hit = req.rd && (req.addr == off);
  endfunction : rd_hit

  // Write strobe aimed at one register
  function automatic logic wr_hit(input bus_req_type req, input logic [7:0] off);
    wr_hit = req.wr && (req.addr == off);
  endfunction : wr_hit

  logic [TICK_W-1:0] prescale;
  logic tick_en;
  logic [7:0] cnt1;
  logic half;
  logic wrap1;
  logic tick1_evt;
  logic [7:0] count_value;
  logic [7:0] reload_value;
  logic wrap2;
  logic tick1_flag;
  logic tick1_irq_enable;
  logic period_select;
  logic tick2_flag;
  logic tick2_irq_enable;
  logic capture_flag;
  logic capture_irq_enable;
  logic [7:0] capture_value_reg;
  logic pin_meta;
  logic pin_sync;
  logic pin_last;
  logic pin_edge;
  logic take_capture;
  guard_state_type guard_state;
  guard_state_type next_guard_state;
  logic guard_enable;
  logic guard_refresh;
  logic guard_cause;
  logic guard_active;
  logic [WDG_W-1:0] guard_cnt;
  logic [HOLD_W-1:0] hold_cnt;
  logic guard_expire;
  logic guard_force;
  logic rd_csr1;
  logic rd_csr2;
  logic rd_capture;
  logic rd_guard;

  assign rd_csr1 = rd_hit(bus_req, OFF_CSR1);
  assign rd_csr2 = rd_hit(bus_req, OFF_CSR2);
  assign rd_capture = rd_hit(bus_req, OFF_CAPTURE);
  assign rd_guard = rd_hit(bus_req, OFF_GUARD);

  // Oscillator/32 enable; halt freezes it, nothing else slows it
  assign tick_en = !halt_mode && (prescale == TICK_W'(TICK_CYCLES - 1));
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prescale <= '0;
    end else if (!halt_mode) begin
      if (tick_en) begin
        prescale <= '0;
      end else begin
        prescale <= prescale + 1'b1;
      end
    end
  end

  // Hidden timebase counter, never on the bus
  assign wrap1 = tick_en && (cnt1 == CNT1_WRAP);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt1 <= ZERO8;
    end else if (wrap1) begin
      cnt1 <= ZERO8;
    end else if (tick_en) begin
      cnt1 <= cnt1 + 1'b1;
    end
  end

  // Long period takes every second wrap, doubling the tick
  assign tick1_evt = wrap1 && (!period_select || half);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      half <= 1'b0;
    end else if (wrap1) begin
      half <= !half;
    end
  end

  // Second counter with reload; reload only sampled at overflow
  assign wrap2 = tick_en && (count_value == CNT2_TOP);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_value <= RELOAD_RST;
    end else if (wrap2) begin
      count_value <= reload_value;
    end else if (tick_en) begin
      count_value <= count_value + 1'b1;
    end
  end

  // Reload register, writable any time
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reload_value <= RELOAD_RST;
    end else if (wr_hit(bus_req, OFF_RELOAD)) begin
      reload_value <= bus_req.wdata;
    end
  end

  // Software control bits of both status registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tick1_irq_enable <= 1'b0;
      period_select <= 1'b0;
      capture_irq_enable <= 1'b0;
      tick2_irq_enable <= 1'b0;
    end else begin
      if (wr_hit(bus_req, OFF_CSR1)) begin
        tick1_irq_enable <= bus_req.wdata[B_T1IE];
        period_select <= bus_req.wdata[B_TB];
        capture_irq_enable <= bus_req.wdata[B_CAPTURE_IRQ_ENABLE];
      end
      if (wr_hit(bus_req, OFF_CSR2)) begin
        tick2_irq_enable <= bus_req.wdata[B_T2IE];
      end
    end
  end

  // Tick flags; a set in the clearing cycle wins, writes ignored
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tick1_flag <= 1'b0;
      tick2_flag <= 1'b0;
    end else begin
      if (tick1_evt) begin
        tick1_flag <= 1'b1;
      end else if (rd_csr1) begin
        tick1_flag <= 1'b0;
      end
      if (wrap2) begin
        tick2_flag <= 1'b1;
      end else if (rd_csr2) begin
        tick2_flag <= 1'b0;
      end
    end
  end

  // Two-stage synchroniser, then a third stage for the edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_last <= 1'b0;
    end else begin
      pin_meta <= capture_input_pin;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end
  assign pin_edge = pin_sync ^ pin_last;

  // Capture only while the flag is clear, so old data survive
  assign take_capture = pin_edge && !capture_flag;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      capture_value_reg <= ZERO8;
    end else if (take_capture) begin
      capture_value_reg <= cnt1;
    end
  end

  // Flag comes up set: software must read the capture register first
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      capture_flag <= CAPF_RST;
    end else if (take_capture) begin
      capture_flag <= 1'b1;
    end else if (rd_capture) begin
      capture_flag <= 1'b0;
    end
  end

  // Interrupt requests, level while flag and enable
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tick1_irq <= 1'b0;
      tick2_irq <= 1'b0;
      capture_irq <= 1'b0;
    end else begin
      tick1_irq <= tick1_flag && tick1_irq_enable;
      tick2_irq <= tick2_flag && tick2_irq_enable;
      capture_irq <= capture_flag && capture_irq_enable;
    end
  end

  // Enable is set-only until reset, so a runaway cannot stop it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      guard_enable <= 1'b0;
    end else if (wr_hit(bus_req, OFF_GUARD) && bus_req.wdata[B_GEN]) begin
      guard_enable <= 1'b1;
    end
  end
  assign guard_active = hw_guard_option || guard_enable;
  assign guard_force = wr_hit(bus_req, OFF_GUARD) && bus_req.wdata[B_GCAUSE];

  // Watchdog sequencing around halt wakeups
  always_comb begin
    next_guard_state = guard_state;
    unique case (guard_state)
      GUARD_OFF: begin
        if (guard_active) begin
          next_guard_state = GUARD_RUN;
        end
      end
      GUARD_RUN: begin
        if (halt_mode && wake_ext) begin
          next_guard_state = GUARD_HOLD;
        end
      end
      GUARD_HOLD: begin
        if (hold_cnt == HOLD_W'(HALT_WAKE_CLKS - 1)) begin
          next_guard_state = GUARD_RUN;
        end
      end
      default: begin
        next_guard_state = GUARD_OFF;
      end
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      guard_state <= GUARD_OFF;
    end else begin
      guard_state <= next_guard_state;
    end
  end

  // Wakeup holdoff in CPU clocks
  always_ff @(posedge clk_sys) begin
    if (reset || guard_state != GUARD_HOLD) begin
      hold_cnt <= '0;
    end else begin
      hold_cnt <= hold_cnt + 1'b1;
    end
  end

  // Interval counter in oscillator/32 ticks
  assign guard_expire = (guard_state == GUARD_RUN) && tick_en
    && (guard_cnt == WDG_W'(WDG_TICKS - 1));
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      guard_cnt <= '0;
    end else if (guard_expire) begin
      guard_cnt <= '0;
    end else if (guard_state == GUARD_RUN && tick_en) begin
      guard_cnt <= guard_cnt + 1'b1;
    end
  end

  // Refresh: software sets, interval end clears; the set wins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      guard_refresh <= 1'b0;
    end else if (wr_hit(bus_req, OFF_GUARD) && bus_req.wdata[B_GREF]) begin
      guard_refresh <= 1'b1;
    end else if (guard_expire) begin
      guard_refresh <= 1'b0;
    end
  end

  // Reset pulse on unrefreshed expiry or on force
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      guard_reset <= 1'b0;
    end else begin
      guard_reset <= guard_force || (guard_expire && !guard_refresh);
    end
  end

  // Cause flag survives the system reset it provokes
  always_ff @(posedge clk_sys) begin
    if (power_on_reset) begin
      guard_cause <= 1'b0;
    end else if (guard_reset) begin
      guard_cause <= 1'b1;
    end else if (rd_guard && !reset) begin
      guard_cause <= 1'b0;
    end
  end

  // Read data one cycle after the strobe, zero when unmapped
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_data <= ZERO8;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFF_CSR2: rd_data <= {6'h00, tick2_irq_enable, tick2_flag};
        OFF_RELOAD: rd_data <= reload_value;
        OFF_CNT2: rd_data <= count_value;
        OFF_CSR1: rd_data <= {capture_irq_enable, capture_flag, period_select,
          tick1_irq_enable, tick1_flag, 3'h0};
        OFF_CAPTURE: rd_data <= capture_value_reg;
        OFF_GUARD: rd_data <= {5'h00, guard_cause, guard_refresh, guard_enable};
        default: rd_data <= ZERO8;
      endcase
    end else begin
      rd_data <= ZERO8;
    end
  end

  // Checks on the block's own behaviour
  a_counter1_range: assert property (@(posedge clk_sys) disable iff (reset)
    cnt1 <= CNT1_WRAP) else $error("hidden counter beyond wrap");
  a_prescale_gap: assert property (@(posedge clk_sys) disable iff (reset)
    tick_en |=> !tick_en [*8]) else $error("ticks too close");
  a_counter1_wrap: assert property (@(posedge clk_sys) disable iff (reset)
    wrap1 |=> cnt1 == ZERO8) else $error("hidden counter wrap wrong");
  a_tick1_set: assert property (@(posedge clk_sys) disable iff (reset)
    tick1_evt |=> tick1_flag ##1 (tick1_irq == tick1_irq_enable))
    else $error("tick1 flag or irq missing");
  a_short_period: assert property (@(posedge clk_sys) disable iff (reset)
    wrap1 && !period_select |-> tick1_evt) else $error("short tick lost");
  a_tick1_clear: assert property (@(posedge clk_sys) disable iff (reset)
    rd_csr1 && !tick1_evt |=> !tick1_flag) else $error("tick1 not cleared");
  a_tick2_clear: assert property (@(posedge clk_sys) disable iff (reset)
    rd_csr2 && !wrap2 |=> !tick2_flag) else $error("tick2 not cleared");
  a_capture_take: assert property (@(posedge clk_sys) disable iff (reset)
    take_capture |=> capture_flag && capture_value_reg == $past(cnt1))
    else $error("capture value wrong");
  a_capture_hold: assert property (@(posedge clk_sys) disable iff (reset)
    capture_flag && !rd_capture |=> capture_flag && $stable(capture_value_reg))
    else $error("capture overwritten");
  a_capture_clear: assert property (@(posedge clk_sys) disable iff (reset)
    rd_capture && !take_capture |=> !capture_flag)
    else $error("capture flag kept");
  a_counter2_reload: assert property (@(posedge clk_sys) disable iff (reset)
    wrap2 |=> count_value == $past(reload_value) && tick2_flag)
    else $error("reload wrong");
  a_force_reset: assert property (@(posedge clk_sys) disable iff (reset)
    guard_force |=> guard_reset ##1 guard_cause)
    else $error("forced reset missing");
  a_expiry_reset: assert property (@(posedge clk_sys) disable iff (reset)
    guard_expire && !guard_refresh |=> guard_reset)
    else $error("expiry without reset");
  a_halt_freeze: assert property (@(posedge clk_sys) disable iff (reset)
    halt_mode |=> $stable(cnt1) && $stable(count_value))
    else $error("counting in halt");
  a_hw_option: assert property (@(posedge clk_sys) disable iff (reset)
    hw_guard_option && guard_state == GUARD_OFF |=> guard_state == GUARD_RUN)
    else $error("hardware watchdog idle");

  c_capture: cover property (@(posedge clk_sys) disable iff (reset) take_capture);
  c_long_tick: cover property (@(posedge clk_sys) disable iff (reset)
    tick1_evt && period_select);
  c_reload: cover property (@(posedge clk_sys) disable iff (reset) wrap2);
  c_wake_hold: cover property (@(posedge clk_sys) disable iff (reset)
    guard_state == GUARD_HOLD ##1 guard_state == GUARD_RUN);
  c_refresh_save: cover property (@(posedge clk_sys) disable iff (reset)
    guard_expire && guard_refresh);

endmodule : lite_timebase_capture_watchdog

`default_nettype wire

// *** testbench/tb_lite_timebase_capture_watchdog.sv ***
// Self-checking bench for the lite timebase, capture and watchdog block
`timescale 1ns/10ps
`default_nettype none

// Compare, count, report at once
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb_lite_timebase_capture_watchdog;
  import lite_timer_pkg::*;
  // Short counts keep the run small
  localparam int TCK = 10;
  localparam int WT = 4;
  logic clk_sys;
  logic reset;
  logic power_on_reset;
  bus_req_type bus_req;
  logic [7:0] rd_data;
  logic capture_input_pin;
  logic hw_guard_option;
  logic halt_mode;
  logic wake_ext;
  logic tick1_irq;
  logic tick2_irq;
  logic capture_irq;
  logic guard_reset;
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 32'h3da7;
  int now = 0;
  int gr_count = 0;
  int t0;
  int i;
  logic [7:0] v;
  logic [7:0] rl;
  logic [7:0] k;

  lite_timebase_capture_watchdog #(.TICK_CYCLES(TCK), .WDG_TICKS(WT)) lite_timebase_capture_watchdog_i (
    .clk_sys(clk_sys),
    .reset(reset),
    .power_on_reset(power_on_reset),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .capture_input_pin(capture_input_pin),
    .hw_guard_option(hw_guard_option),
    .halt_mode(halt_mode),
    .wake_ext(wake_ext),
    .tick1_irq(tick1_irq),
    .tick2_irq(tick2_irq),
    .capture_irq(capture_irq),
    .guard_reset(guard_reset)
  );

  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Cycle stamp and count of watchdog reset pulses
  always @(posedge clk_sys) begin
    now <= now + 1;
    if (guard_reset === 1'b1) gr_count <= gr_count + 1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask : wr

  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  task automatic chkrd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask : chkrd

  // Synchronous reset held for 8 cycles
  task automatic do_reset(input logic por);
    @(posedge clk_sys);
    reset <= 1'b1;
    power_on_reset <= por;
    cyc(8);
    reset <= 1'b0;
    power_on_reset <= 1'b0;
  endtask : do_reset

  // Wait for the first tick interrupt to rise, stamp it
  task automatic wait_t1(output int t);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1;
    while (tick1_irq !== 1'b1 && n < 12000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK(tick1_irq, 1'b1)
    t = now;
  endtask : wait_t1

  // Poll the second counter up to FFh, then return the value after it
  task automatic wrap_cnt(output logic [7:0] d);
    int n;
    n = 0;
    d = 8'h00;
    while (d !== 8'hff && n < 3000) begin
      rd(OFF_CNT2, d);
      n++;
    end
    `CHK(d, 8'hff)
    n = 0;
    while (d === 8'hff && n < 100) begin
      rd(OFF_CNT2, d);
      n++;
    end
  endtask : wrap_cnt

  task automatic final_report();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // Hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    final_report();
  end

  // Main sequence
  initial begin
    reset = 1'b1;
    power_on_reset = 1'b1;
    bus_req = '0;
    capture_input_pin = 1'b0;
    hw_guard_option = 1'b0;
    halt_mode = 1'b0;
    wake_ext = 1'b0;
    do_reset(1'b1);
    // Reset values, unmapped place
    chkrd(OFF_CSR2, 8'h00);
    chkrd(OFF_RELOAD, RELOAD_RST);
    chkrd(OFF_CSR1, 8'h40);
    chkrd(OFF_GUARD, 8'h00);
    wr(8'h20, 8'h5a);
    chkrd(8'h20, 8'h00);
    chkrd(OFF_CAPTURE, 8'h00);
    chkrd(OFF_CSR1, 8'h00);
    // Auto-reload counter with a random reload value
    rl = {2'b10, 6'($random(seed))};
    wr(OFF_RELOAD, rl);
    chkrd(OFF_RELOAD, rl);
    wr(OFF_CSR2, 8'h03);
    chkrd(OFF_CSR2, 8'h02);
    wrap_cnt(v);
    `CHK(v, rl)
    cyc(2);
    #1 `CHK(tick2_irq, 1'b1)
    chkrd(OFF_CSR2, 8'h03);
    cyc(2);
    #1 `CHK(tick2_irq, 1'b0)
    chkrd(OFF_CSR2, 8'h02);
    wr(OFF_RELOAD, 8'h31);
    rd(OFF_CNT2, v);
    `CHK(v[7], 1'b1)
    wrap_cnt(v);
    `CHK(v, 8'h31)
    // Timebase tick, both periods; clear after enabling so no stale flag stamps t0
    wr(OFF_CSR1, 8'h10);
    rd(OFF_CSR1, v);
    wait_t1(t0);
    wr(OFF_CSR1, 8'h10);
    cyc(2);
    #1 `CHK(tick1_irq, 1'b1)
    chkrd(OFF_CSR1, 8'h18);
    cyc(2);
    #1 `CHK(tick1_irq, 1'b0)
    wait_t1(i);
    `CHK(i - t0, 250 * TCK)
    wr(OFF_CSR1, 8'h30);
    rd(OFF_CSR1, v);
    wait_t1(t0);
    rd(OFF_CSR1, v);
    wait_t1(i);
    `CHK(i - t0, 500 * TCK)
    // Capture at a random distance after a wrap
    wr(OFF_CSR1, 8'h90);
    rd(OFF_CSR1, v);
    wait_t1(t0);
    k = 8'(1 + ($random(seed) & 127));
    cyc(TCK * int'(k) + 1);
    capture_input_pin <= ~capture_input_pin;
    cyc(10);
    #1 `CHK(capture_irq, 1'b1)
    wr(OFF_CSR1, 8'h90);
    capture_input_pin <= ~capture_input_pin;
    cyc(20);
    chkrd(OFF_CSR1, 8'hd8);
    chkrd(OFF_CAPTURE, k);
    cyc(2);
    #1 `CHK(capture_irq, 1'b0)
    chkrd(OFF_CSR1, 8'h90);
    // Halt freezes the second counter
    @(posedge clk_sys);
    halt_mode <= 1'b1;
    cyc(2);
    rd(OFF_CNT2, v);
    cyc(60);
    chkrd(OFF_CNT2, v);
    @(posedge clk_sys);
    halt_mode <= 1'b0;
    // Watchdog refreshed, then starved
    wr(OFF_GUARD, 8'h01);
    for (i = 0; i < 10; i++) begin
      cyc(15);
      wr(OFF_GUARD, 8'h02);
    end
    `CHK(gr_count, 0)
    cyc(38);
    `CHK(gr_count, 0)
    cyc(50);
    `CHK(gr_count > 0, 1'b1)
    do_reset(1'b0);
    chkrd(OFF_GUARD, 8'h04);
    chkrd(OFF_GUARD, 8'h00);
    i = gr_count;
    cyc(200);
    `CHK(gr_count, i)
    // Forced reset
    wr(OFF_GUARD, 8'h04);
    #1 `CHK(guard_reset, 1'b1)
    do_reset(1'b0);
    chkrd(OFF_GUARD, 8'h04);
    // Hardware option overrides the cleared enable
    @(posedge clk_sys);
    hw_guard_option <= 1'b1;
    i = gr_count;
    cyc(100);
    `CHK(gr_count > i, 1'b1)
    hw_guard_option <= 1'b0;
    do_reset(1'b1);
    chkrd(OFF_GUARD, 8'h00);
    // Halt with the watchdog on, then wake by external event
    wr(OFF_GUARD, 8'h03);
    halt_mode <= 1'b1;
    i = gr_count;
    cyc(300);
    `CHK(gr_count, i)
    wake_ext <= 1'b1;
    cyc(1);
    wake_ext <= 1'b0;
    halt_mode <= 1'b0;
    cyc(4000);
    `CHK(gr_count, i)
    cyc(200);
    `CHK(gr_count > i, 1'b1)
    final_report();
  end
endmodule : tb_lite_timebase_capture_watchdog

`default_nettype wire
